// ===== bulk_in_pkg.sv
// shared constants and carriers of the bulk-in frame packer
// assumes a 20 MHz system clock and word-wide show-ahead fifo reads
package bulk_in_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int DLY_UNIT_NS = 1000;
  localparam int DLY_UNIT_CYC =
    (DLY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] PKT_BYTES = 10'h200;
  localparam logic [12:0] PKT_WORDS = 13'h0080;
  localparam logic [9:0] WORD_BYTES = 10'h004;
  localparam logic [7:0] CAP_MIN = 8'h04;
  localparam logic [18:0] CAP_SLACK = 19'h00004;
  localparam int LEN_LSB = 0;
  localparam int LEN_MSB = 13;
  localparam logic [7:0] DLY_RESET = 8'h22;

  typedef enum logic [1:0] {
    RESP_NAK = 2'b00,
    RESP_ZLP = 2'b01,
    RESP_DATA = 2'b10
  } resp_kind_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_STREAM = 2'b01,
    S_WAIT = 2'b10
  } sys_state_t;

  typedef struct packed {
    resp_kind_t kind;
    logic [9:0] len;
  } resp_t;

  typedef struct packed {
    logic [31:0] data;
    logic [2:0] bytes;
    logic first;
    logic valid;
  } tx_word_t;

  typedef struct packed {
    logic multi_frame_packing;
    logic cap_en;
    logic empty_nak;
    logic [7:0] cap;
    logic [7:0] dly;
  } cfg_t;

  typedef struct packed {
    sys_state_t state;
    logic [2:0] tok_s;
    logic [2:0] ack_s;
    logic [2:0] tmo_s;
    logic resp_tgl;
    resp_t resp;
    logic [13:0] frm_rem;
    logic [13:0] snap_rem;
    logic [9:0] pkt_len;
    logic [9:0] saved_len;
    logic [18:0] burst;
    logic [12:0] timer;
    logic burst_open;
    logic zlp_due;
    logic replay;
    logic stop;
    logic was_empty;
    tx_word_t tx;
    logic tx_end;
    logic rd;
    logic rewind;
    logic advance;
  } sys_t;

  typedef struct packed {
    logic [2:0] rst_s;
    logic tok_tgl;
    logic ack_tgl;
    logic tmo_tgl;
    logic [2:0] rsp_s;
    resp_t resp;
    logic resp_valid;
    logic stall;
  } link_t;

  localparam sys_t SYS_RST = '0;
  localparam link_t LINK_RST = '0;
endpackage : bulk_in_pkg

// ===== bulk_in_transmitter.sv
// bulk-in transmitter: packs fifo frames into 512-byte bulk-in packets
// fifo side on clock_in; token and handshake side on usb_clk_in
// Notes on behaviour
// - one mode bit picks multi-frame or single-frame packing
// - multi-frame packs several frames; long frames span several packets
// - single-frame mode never starts a second frame inside a packet
// - status word ahead of each frame gives its length for packing
// - every burst ends with a short packet or zero-length packet
// - single-frame: frame of whole packet multiples is followed by zlp
// - frames start word-aligned; pad last word only when another follows
// - alignment pad bytes are not counted in the status length
// - single-frame mode never pads; transfer ends on last frame byte
// - token on empty fifo answered with zlp, per empty response bit
// - unacked terminator is resent unchanged before any new frame
// - multi-frame waits programmed delay before ending burst; zero disables
// - timer starts after full packet; full packet first restarts it
// - lone short frame into empty fifo starts the delay timer
// - tokens get nak while the delay timer runs and the fifo holds under a packet
// - burst limit enabled: zlp once burst amount reaches the limit
// - burst limit of 4 or less disables enforcement
// - inactive limit: empty token gets zlp if bit 0, nak if 1
// - active limit: burst ends within last four bytes of limit
// - fifo fill level decides when a burst has ended
// - unacked packet is rewound and resent; advance only after ack
// - active burst limit splits a frame across bursts only if it opens the burst and exceeds the limit
// - the endpoint is never stalled by this block
module bulk_in_transmitter (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic usb_clk_in,
  input wire bulk_in_pkg::cfg_t cfg_in,
  input wire logic [12:0] fifo_words_in,
  input wire logic [31:0] fifo_data_in,
  output logic fifo_rd_out,
  output logic fifo_rewind_out,
  output logic fifo_advance_out,
  output bulk_in_pkg::tx_word_t tx_out,
  output logic tx_end_out,
  input wire logic token_in,
  input wire logic host_ack_in,
  input wire logic host_timeout_in,
  output bulk_in_pkg::resp_t resp_out,
  output logic resp_valid_out,
  output logic ep_stall_out
);
  bulk_in_pkg::sys_t s_r;
  bulk_in_pkg::sys_t s_nxt;
  bulk_in_pkg::link_t l_r;
  bulk_in_pkg::link_t l_nxt;

  logic tok_evt;
  logic ack_evt;
  logic tmo_evt;
  logic tmr_run;
  logic cap_on;
  logic mef_dly;
  logic link_rst;
  logic [12:0] dly_cyc;
  logic [18:0] budget;

  // toggle edges counted when second and third stages differ
  assign tok_evt = s_r.tok_s[1] ^ s_r.tok_s[2];
  assign ack_evt = s_r.ack_s[1] ^ s_r.ack_s[2];
  assign tmo_evt = s_r.tmo_s[1] ^ s_r.tmo_s[2];
  assign tmr_run = (s_r.timer != '0);
  assign cap_on = cfg_in.cap_en && (cfg_in.cap > bulk_in_pkg::CAP_MIN);
  assign mef_dly = cfg_in.multi_frame_packing && (cfg_in.dly != '0);
  assign dly_cyc = 13'(cfg_in.dly * bulk_in_pkg::DLY_UNIT_CYC);
  assign budget = 19'(cfg_in.cap * bulk_in_pkg::PKT_BYTES);
  assign link_rst = l_r.rst_s[2];

  // system side: packet building and handshake bookkeeping
  always_comb begin
    logic go;
    logic pad;
    logic fits;
    logic [13:0] flen;
    logic [9:0] b;
    logic [18:0] nb;
    bulk_in_pkg::resp_kind_t k;
    go = 1'b0;
    pad = 1'b0;
    fits = 1'b0;
    flen = '0;
    b = '0;
    nb = '0;
    k = bulk_in_pkg::RESP_NAK;
    s_nxt = s_r;
    s_nxt.tok_s = {s_r.tok_s[1:0], l_r.tok_tgl};
    s_nxt.ack_s = {s_r.ack_s[1:0], l_r.ack_tgl};
    s_nxt.tmo_s = {s_r.tmo_s[1:0], l_r.tmo_tgl};
    s_nxt.rd = 1'b0;
    s_nxt.rewind = 1'b0;
    s_nxt.advance = 1'b0;
    s_nxt.tx.valid = 1'b0;
    s_nxt.tx.first = 1'b0;
    s_nxt.tx_end = 1'b0;
    s_nxt.was_empty = (fifo_words_in == '0);
    if (tmr_run) begin
      s_nxt.timer = s_r.timer - 13'h0001;
    end
    if (mef_dly && s_r.was_empty && !s_nxt.was_empty && !s_r.burst_open
        && !tmr_run && s_r.state == bulk_in_pkg::S_IDLE) begin
      s_nxt.timer = dly_cyc;
    end
    case (s_r.state)
      bulk_in_pkg::S_IDLE: begin
        if (tok_evt) begin
          if (s_r.replay) begin
            s_nxt.state = bulk_in_pkg::S_STREAM;
            s_nxt.pkt_len = '0;
            s_nxt.stop = 1'b0;
          end else if (tmr_run && fifo_words_in < bulk_in_pkg::PKT_WORDS) begin
            go = 1'b1;
            k = bulk_in_pkg::RESP_NAK;
          end else if (s_r.zlp_due) begin
            go = 1'b1;
            k = bulk_in_pkg::RESP_ZLP;
          end else if (fifo_words_in == '0) begin
            go = 1'b1;
            k = (s_r.burst_open || cap_on || !cfg_in.empty_nak) ?
                bulk_in_pkg::RESP_ZLP : bulk_in_pkg::RESP_NAK;
          end else begin
            s_nxt.state = bulk_in_pkg::S_STREAM;
            s_nxt.pkt_len = '0;
            s_nxt.snap_rem = s_r.frm_rem;
            s_nxt.stop = 1'b0;
          end
        end
      end
      bulk_in_pkg::S_STREAM: begin
        if (s_r.stop || s_r.pkt_len == bulk_in_pkg::PKT_BYTES ||
            (s_r.replay && s_r.pkt_len == s_r.saved_len)) begin
          go = 1'b1;
          s_nxt.tx_end = 1'b1;
          k = (s_r.pkt_len == '0) ? bulk_in_pkg::RESP_ZLP :
              bulk_in_pkg::RESP_DATA;
        end else if (s_r.rd) begin
          // fifo still moving past the word just taken
        end else if (s_r.frm_rem == '0) begin
          flen = fifo_data_in[bulk_in_pkg::LEN_MSB:bulk_in_pkg::LEN_LSB];
          fits = !cap_on || (s_r.burst + 19'(s_r.pkt_len) == '0) ||
                 (s_r.burst + 19'(s_r.pkt_len) + 19'(flen) +
                  19'(bulk_in_pkg::WORD_BYTES) <= budget);
          if (fifo_words_in != '0 && (cfg_in.multi_frame_packing || s_r.pkt_len == '0)
              && (s_r.replay || fits)) begin
            s_nxt.rd = 1'b1;
            s_nxt.tx.valid = 1'b1;
            s_nxt.tx.first = 1'b1;
            s_nxt.tx.data = fifo_data_in;
            s_nxt.tx.bytes = 3'h4;
            s_nxt.pkt_len = s_r.pkt_len + bulk_in_pkg::WORD_BYTES;
            s_nxt.frm_rem = flen;
          end else begin
            s_nxt.stop = 1'b1;
          end
        end else if (fifo_words_in != '0) begin
          s_nxt.rd = 1'b1;
          s_nxt.tx.valid = 1'b1;
          s_nxt.tx.data = fifo_data_in;
          if (s_r.frm_rem <= 14'(bulk_in_pkg::WORD_BYTES)) begin
            if (s_r.replay) begin
              pad = (s_r.pkt_len + bulk_in_pkg::WORD_BYTES
                     <= s_r.saved_len);
            end else begin
              pad = cfg_in.multi_frame_packing && (fifo_words_in > 13'h0001);
            end
            b = pad ? bulk_in_pkg::WORD_BYTES : 10'(s_r.frm_rem);
            s_nxt.frm_rem = '0;
            s_nxt.stop = !pad;
          end else begin
            b = bulk_in_pkg::WORD_BYTES;
            s_nxt.frm_rem = s_r.frm_rem - 14'(bulk_in_pkg::WORD_BYTES);
          end
          s_nxt.tx.bytes = b[2:0];
          s_nxt.pkt_len = s_r.pkt_len + b;
        end
      end
      bulk_in_pkg::S_WAIT: begin
        if (ack_evt) begin
          s_nxt.advance = 1'b1;
          s_nxt.replay = 1'b0;
          s_nxt.state = bulk_in_pkg::S_IDLE;
          nb = s_r.burst + 19'(s_r.resp.len);
          if (s_r.resp.len == bulk_in_pkg::PKT_BYTES) begin
            s_nxt.burst = nb;
            s_nxt.burst_open = 1'b1;
            s_nxt.zlp_due = (!cfg_in.multi_frame_packing && s_r.frm_rem == '0) ||
                            (cap_on && nb + bulk_in_pkg::CAP_SLACK >= budget);
            if (mef_dly) begin
              s_nxt.timer = dly_cyc;
            end
          end else begin
            s_nxt.burst = '0;
            s_nxt.burst_open = 1'b0;
            s_nxt.zlp_due = 1'b0;
            s_nxt.timer = '0;
          end
        end else if (tmo_evt) begin
          s_nxt.rewind = 1'b1;
          s_nxt.replay = 1'b1;
          s_nxt.saved_len = s_r.resp.len;
          s_nxt.frm_rem = s_r.snap_rem;
          s_nxt.state = bulk_in_pkg::S_IDLE;
        end
      end
      default: begin
        s_nxt.state = bulk_in_pkg::S_IDLE;
      end
    endcase
    if (go) begin
      s_nxt.resp.kind = k;
      s_nxt.resp.len = (k == bulk_in_pkg::RESP_DATA) ? s_r.pkt_len : '0;
      s_nxt.resp_tgl = ~s_r.resp_tgl;
      s_nxt.state = (k == bulk_in_pkg::RESP_NAK) ? bulk_in_pkg::S_IDLE :
                    bulk_in_pkg::S_WAIT;
    end
    if (srst_in) begin
      s_nxt = bulk_in_pkg::SYS_RST;
    end
  end

  always_ff @(posedge clock_in) begin
    s_r <= s_nxt;
  end

  // link side: token and handshake events, answers from the engine
  always_comb begin
    l_nxt = l_r;
    l_nxt.rst_s = {l_r.rst_s[1:0], srst_in};
    l_nxt.rsp_s = {l_r.rsp_s[1:0], s_r.resp_tgl};
    l_nxt.resp_valid = 1'b0;
    l_nxt.stall = 1'b0;
    if (token_in) begin
      l_nxt.tok_tgl = ~l_r.tok_tgl;
    end
    if (host_ack_in) begin
      l_nxt.ack_tgl = ~l_r.ack_tgl;
    end
    if (host_timeout_in) begin
      l_nxt.tmo_tgl = ~l_r.tmo_tgl;
    end
    if (l_r.rsp_s[1] ^ l_r.rsp_s[2]) begin
      l_nxt.resp = s_r.resp;
      l_nxt.resp_valid = 1'b1;
    end
    if (link_rst) begin
      l_nxt = bulk_in_pkg::LINK_RST;
      l_nxt.rst_s = {l_r.rst_s[1:0], srst_in};
    end
  end

  always_ff @(posedge usb_clk_in) begin
    l_r <= l_nxt;
  end

  assign fifo_rd_out = s_r.rd;
  assign fifo_rewind_out = s_r.rewind;
  assign fifo_advance_out = s_r.advance;
  assign tx_out = s_r.tx;
  assign tx_end_out = s_r.tx_end;
  assign resp_out = l_r.resp;
  assign resp_valid_out = l_r.resp_valid;
  assign ep_stall_out = l_r.stall;

  // checks
  property p_sef_one_frame;
    @(posedge clock_in) disable iff (srst_in)
    (tx_out.valid && tx_out.first && !cfg_in.multi_frame_packing) |->
      s_r.pkt_len == bulk_in_pkg::WORD_BYTES;
  endproperty
  a_sef_one_frame: assert property (p_sef_one_frame)
    else $error("second frame started in single-frame packet");

  property p_pkt_max;
    @(posedge clock_in) disable iff (srst_in)
    tx_out.valid |-> s_r.pkt_len <= bulk_in_pkg::PKT_BYTES;
  endproperty
  a_pkt_max: assert property (p_pkt_max)
    else $error("packet grew past 512 bytes");

  property p_nak_in_delay;
    @(posedge clock_in) disable iff (srst_in)
    (s_r.state == bulk_in_pkg::S_IDLE && tok_evt && !s_r.replay && tmr_run
     && fifo_words_in < bulk_in_pkg::PKT_WORDS) |=>
      s_r.resp.kind == bulk_in_pkg::RESP_NAK && $changed(s_r.resp_tgl);
  endproperty
  a_nak_in_delay: assert property (p_nak_in_delay)
    else $error("token not refused while delay runs");

  property p_rewind;
    @(posedge clock_in) disable iff (srst_in)
    (s_r.state == bulk_in_pkg::S_WAIT && !ack_evt && tmo_evt) |=>
      fifo_rewind_out && !fifo_advance_out ##1 !fifo_rewind_out;
  endproperty
  a_rewind: assert property (p_rewind)
    else $error("missed ack did not rewind once");

  property p_advance_after_ack;
    @(posedge clock_in) disable iff (srst_in)
    fifo_advance_out |-> $past(s_r.state) == bulk_in_pkg::S_WAIT
      && $past(ack_evt);
  endproperty
  a_advance_after_ack: assert property (p_advance_after_ack)
    else $error("read pointer advanced without ack");

  property p_sef_no_pad;
    @(posedge clock_in) disable iff (srst_in)
    (tx_out.valid && !cfg_in.multi_frame_packing && tx_out.bytes != 3'h4) |=>
      !tx_out.valid && tx_end_out;
  endproperty
  a_sef_no_pad: assert property (p_sef_no_pad)
    else $error("single-frame transfer ran past last byte");

  property p_empty_response;
    @(posedge clock_in) disable iff (srst_in)
    (s_r.state == bulk_in_pkg::S_IDLE && tok_evt && !s_r.replay && !tmr_run
     && !s_r.zlp_due && fifo_words_in == '0 && !s_r.burst_open && !cap_on)
    |=> s_r.resp.kind == (cfg_in.empty_nak ? bulk_in_pkg::RESP_NAK :
                          bulk_in_pkg::RESP_ZLP);
  endproperty
  a_empty_response: assert property (p_empty_response)
    else $error("wrong answer to token on empty fifo");

  property p_sef_zlp_due;
    @(posedge clock_in) disable iff (srst_in)
    (s_r.state == bulk_in_pkg::S_WAIT && ack_evt && !cfg_in.multi_frame_packing
     && s_r.resp.len == bulk_in_pkg::PKT_BYTES && s_r.frm_rem == '0)
    |=> s_r.zlp_due;
  endproperty
  a_sef_zlp_due: assert property (p_sef_zlp_due)
    else $error("full-size frame end not followed by zlp");

  property p_no_stall;
    @(posedge usb_clk_in) disable iff (link_rst)
    !ep_stall_out;
  endproperty
  a_no_stall: assert property (p_no_stall)
    else $error("endpoint stalled by transmitter");

  property p_resp_pass;
    @(posedge usb_clk_in) disable iff (link_rst)
    (l_r.rsp_s[1] ^ l_r.rsp_s[2]) |=> resp_valid_out ##1 !resp_valid_out;
  endproperty
  a_resp_pass: assert property (p_resp_pass)
    else $error("answer not passed to link as one pulse");
endmodule : bulk_in_transmitter

// ===== bulk_in_host_model.sv
// usb host model: bulk-in tokens and handshakes on the link clock
// assumes the transmitter answers each token with one response pulse
module bulk_in_host_model (
  input wire logic usb_clk_in,
  input wire bulk_in_pkg::resp_t resp_in,
  input wire logic resp_valid_in,
  output logic token_out,
  output logic ack_out,
  output logic timeout_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    token_out = 1'b0;
    ack_out = 1'b0;
    timeout_out = 1'b0;
  end

  // one token; data or zlp answers get an ack or a missed ack
  task automatic transact(input logic ack, output logic [11:0] seen);
    int n;
    seen = 12'hFFF;
    @(posedge usb_clk_in);
    token_out <= 1'b1;
    @(posedge usb_clk_in);
    token_out <= 1'b0;
    for (n = 0; n < 600; n++) begin
      @(posedge usb_clk_in);
      if (resp_valid_in === 1'b1) begin
        seen = resp_in;
        break;
      end
    end
    if (seen !== 12'hFFF && seen[11:10] !== bulk_in_pkg::RESP_NAK) begin
      ack_out <= ack;
      timeout_out <= !ack;
      @(posedge usb_clk_in);
      ack_out <= 1'b0;
      timeout_out <= 1'b0;
    end
    // let advance or rewind cross before the next token
    repeat (8) @(posedge usb_clk_in);
  endtask : transact
endmodule : bulk_in_host_model

// ===== usb_bulk_in_frame_packer_tb.sv
// self-checking bench of the bulk-in transmitter with a fifo model
// assumes the host model drives the link side on its own clock
module usb_bulk_in_frame_packer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in;
  logic srst_in;
  logic usb_clk_in;
  bulk_in_pkg::cfg_t cfg;
  bulk_in_pkg::resp_t resp;
  logic [31:0] mem [0:1023];
  logic [12:0] wptr;
  logic [12:0] rptr;
  logic [12:0] cptr;
  logic rd, rew, adv, stall, tok, ack, tmo, rvalid;
  int mismatches;
  int compares;
  bulk_in_pkg::tx_word_t txw;
  logic txe;
  int txsum = 0;
  int txends = 0;

  bulk_in_transmitter bulk_in_transmitter_inst (
    .clock_in(clock_in), .srst_in(srst_in), .usb_clk_in(usb_clk_in),
    .cfg_in(cfg), .fifo_words_in(wptr - rptr),
    .fifo_data_in(mem[rptr[9:0]]), .fifo_rd_out(rd),
    .fifo_rewind_out(rew), .fifo_advance_out(adv), .tx_out(txw),
    .tx_end_out(txe), .token_in(tok), .host_ack_in(ack),
    .host_timeout_in(tmo), .resp_out(resp), .resp_valid_out(rvalid),
    .ep_stall_out(stall)
  );

  bulk_in_host_model bulk_in_host_model_inst (
    .usb_clk_in(usb_clk_in), .resp_in(resp), .resp_valid_in(rvalid),
    .token_out(tok), .ack_out(ack), .timeout_out(tmo)
  );

  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  initial begin
    usb_clk_in = 1'b0;
    #17.3;
    forever #62.5 usb_clk_in = ~usb_clk_in;
  end

  // fifo read pointer with a commit point for replay
  always @(posedge clock_in) begin
    if (rew === 1'b1) begin
      rptr <= cptr;
    end else if (rd === 1'b1) begin
      rptr <= rptr + 13'h0001;
    end
    if (adv === 1'b1) begin
      cptr <= rptr;
    end
  end

  // bytes and packet ends seen on the transmit word stream
  always @(posedge clock_in) begin
    if (txw.valid === 1'b1) begin
      txsum <= txsum + int'(txw.bytes);
    end
    if (txe === 1'b1) begin
      txends <= txends + 1;
    end
  end

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [15:0] got,
      input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic set_cfg(input logic multi_frame_packing, input logic nak,
      input logic [7:0] dly);
    @(posedge clock_in);
    cfg <= {multi_frame_packing, 1'b0, nak, 8'h00, dly};
  endtask : set_cfg

  // status word then payload, shown to the block only when whole
  task automatic push(input logic [13:0] len);
    int i;
    int n;
    n = (len + 3) / 4;
    @(posedge clock_in);
    mem[wptr[9:0]] <= {18'h00000, len};
    for (i = 1; i <= n; i++) begin
      mem[wptr[9:0] + i[9:0]] <= {8'hA5, i[23:0]};
    end
    wptr <= wptr + 13'(n + 1);
    @(posedge clock_in);
  endtask : push

  task automatic token(input logic ok, input logic [1:0] kind,
      input logic [9:0] len, input string name);
    logic [11:0] seen;
    int b0;
    int e0;
    b0 = txsum;
    e0 = txends;
    bulk_in_host_model_inst.transact(ok, seen);
    if (seen === 12'hFFF) begin
      mismatches++;
      test_done;
    end
    check({name, " kind"}, {14'h0000, seen[11:10]}, {14'h0000, kind});
    if (kind !== bulk_in_pkg::RESP_NAK) begin
      check({name, " len"}, {6'h00, seen[9:0]}, {6'h00, len});
    end
    check({name, " bytes"}, 16'(txsum - b0),
        (kind === bulk_in_pkg::RESP_DATA) ? {6'h00, len} : 16'h0000);
    check({name, " ends"}, 16'(txends - e0),
        (kind === bulk_in_pkg::RESP_DATA) ? 16'h0001 : 16'h0000);
  endtask : token

  task automatic t_empty;
    set_cfg(1'b1, 1'b0, 8'h00);
    token(1'b1, bulk_in_pkg::RESP_ZLP, 10'h000, "empty zlp");
    set_cfg(1'b1, 1'b1, 8'h00);
    token(1'b1, bulk_in_pkg::RESP_NAK, 10'h000, "empty nak");
  endtask : t_empty

  task automatic t_mef;
    set_cfg(1'b1, 1'b0, 8'h00);
    push(14'h0005);
    push(14'h0008);
    token(1'b1, bulk_in_pkg::RESP_DATA, 10'h018, "mef pair");
    push(14'h0258);
    token(1'b1, bulk_in_pkg::RESP_DATA, 10'h200, "split a");
    token(1'b1, bulk_in_pkg::RESP_DATA, 10'h05C, "split b");
  endtask : t_mef

  task automatic t_sef;
    set_cfg(1'b0, 1'b0, 8'h00);
    push(14'h0005);
    push(14'h0008);
    token(1'b1, bulk_in_pkg::RESP_DATA, 10'h009, "sef one");
    token(1'b1, bulk_in_pkg::RESP_DATA, 10'h00C, "sef two");
    push(14'h01FC);
    token(1'b1, bulk_in_pkg::RESP_DATA, 10'h200, "sef full");
    token(1'b1, bulk_in_pkg::RESP_ZLP, 10'h000, "sef zlp");
  endtask : t_sef

  task automatic t_replay;
    set_cfg(1'b1, 1'b0, 8'h00);
    push(14'h0005);
    token(1'b0, bulk_in_pkg::RESP_DATA, 10'h009, "lost");
    push(14'h0008);
    token(1'b1, bulk_in_pkg::RESP_DATA, 10'h009, "replay");
    token(1'b1, bulk_in_pkg::RESP_DATA, 10'h00C, "next");
  endtask : t_replay

  task automatic t_delay;
    set_cfg(1'b1, 1'b0, 8'h02);
    push(14'h0005);
    token(1'b1, bulk_in_pkg::RESP_NAK, 10'h000, "held");
    repeat (60) @(posedge clock_in);
    token(1'b1, bulk_in_pkg::RESP_DATA, 10'h009, "expired");
  endtask : t_delay

  initial begin
    srst_in = 1'b1;
    cfg = '0;
    wptr = '0;
    rptr = '0;
    cptr = '0;
    mismatches = 0;
    compares = 0;
    repeat (10) @(posedge clock_in);
    srst_in <= 1'b0;
    repeat (10) @(posedge clock_in);
    t_empty;
    t_mef;
    t_sef;
    t_replay;
    t_delay;
    check("stall", {15'h0000, stall}, 16'h0000);
    test_done;
  end
endmodule : usb_bulk_in_frame_packer_tb
